// >>> rtl/bcbt_cond.v
`timescale 1ns/10ps
`default_nettype none
`include "bcbt_defs.vh"

// branch condition evaluator
module bcbt_cond (
    // opcode and inputs under test
    input wire [7:0] opcode,
    input wire [7:0] condition_flag_register,
    input wire irq_pin,
    // results
    output reg is_branch,
    output reg take
);
    // one condition per opcode; others are not branches
    always @* begin
        is_branch = 1'b1;
        take = 1'b0;
        case (opcode)
            `BCBT_OP_PIN_HIGH: take = irq_pin; // [RULE1]
            `BCBT_OP_PIN_LOW: take = ~irq_pin; // [RULE2]
            `BCBT_OP_SIGNED_LE: take = condition_flag_register[`BCBT_CCR_Z] | (condition_flag_register[`BCBT_CCR_N] ^ condition_flag_register[`BCBT_CCR_V]); // [RULE7]
            `BCBT_OP_LOWER: take = condition_flag_register[`BCBT_CCR_C]; // [RULE8]
            `BCBT_OP_LOWER_SAME: take = condition_flag_register[`BCBT_CCR_C] | condition_flag_register[`BCBT_CCR_Z]; // [RULE9]
            `BCBT_OP_NEGATIVE: take = condition_flag_register[`BCBT_CCR_N]; // [RULE10]
            `BCBT_OP_SIGNED_LESS: take = condition_flag_register[`BCBT_CCR_N] ^ condition_flag_register[`BCBT_CCR_V]; // [RULE13]
            `BCBT_OP_MASK_CLEAR: take = ~condition_flag_register[`BCBT_CCR_I]; // [RULE14]
            default: is_branch = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> rtl/bcbt_core.v
// Notes on behaviour
// RULE1 - pin-high branch 2f, taken on high pin
// RULE2 - pin-low branch 2e, taken on low pin
// RULE3 - target is opcode address plus two plus offset
// RULE4 - bit-test ands, writes neither accumulator nor memory
// RULE5 - bit-test clears v, sets n, z only
// RULE6 - bit-test in eight forms, stack forms prefixed
// RULE7 - signed less-equal 93: z or n xor v
// RULE8 - unsigned lower 25: carry set
// RULE9 - unsigned lower-same 23: carry or zero
// RULE10 - negative branch 2b: n set
// RULE11 - loads and stores copy msb into n
// RULE12 - moves and tests leave carry untouched
// RULE13 - signed less 91: n xor v
// RULE14 - mask-clear branch 2c: i flag zero
// RULE15 - taken adds sign-extended offset, else fall through
`timescale 1ns/10ps
`default_nettype none
`include "bcbt_defs.vh"

module bcbt_core (
    // clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // program memory read port, data valid in the read cycle
    output wire mem_rd,
    output wire [15:0] mem_addr,
    input wire [7:0] mem_rdata,
    // external interrupt pin level
    input wire irq_pin,
    // load or store from the rest of the processor
    input wire mv_valid,
    input wire mv_wide,
    input wire [15:0] mv_data,
    // status
    output wire busy
);
    // one-hot sequencer states
    localparam S_IDLE = 6'h01;
    localparam S_FETCH = 6'h02;
    localparam S_OP1 = 6'h04;
    localparam S_OP2 = 6'h08;
    localparam S_DATA = 6'h10;
    localparam S_HOLD = 6'h20;

    // architectural state
    reg [15:0] pc_ff, nxt_pc; // program counter
    reg [7:0] acc_ff, nxt_acc; // accumulator
    reg [15:0] hx_ff, nxt_hx; // index pair
    reg [15:0] sp_ff, nxt_sp; // stack pointer
    reg [7:0] ccr_ff, nxt_ccr; // condition flags
    // sequencer state
    reg [5:0] st_ff, nxt_st; // current state
    reg [15:0] opa_ff, nxt_opa; // address of the opcode
    reg [7:0] opc_ff, nxt_opc; // opcode under execution
    reg pre_ff, nxt_pre; // prefix byte seen
    reg [7:0] b1_ff, nxt_b1; // first operand byte
    reg [15:0] ea_ff, nxt_ea; // effective address
    reg [2:0] cnt_ff, nxt_cnt; // cycles spent so far
    reg [2:0] need_ff, nxt_need; // cycles the instruction takes
    // control and status
    reg run_ff, nxt_run; // free-running execution
    reg step_ff, nxt_step; // one-instruction request
    reg ill_ff, nxt_ill; // sticky unknown-opcode flag
    reg [31:0] prdata_ff; // read data of this transfer

    // helpers of the sequencer
    reg fin; // instruction work done; hold cycles may still follow
    reg bt_exec; // bit-test operand on the bus
    reg [2:0] d_need; // cycle count of decoded form
    reg [31:0] rd_mux; // register read selection
    reg hit; // address decodes to a register

    wire st_idle = st_ff[0];
    wire st_fetch = st_ff[1];
    wire st_data = st_ff[4];

    // opcode from the bus in fetch, held later
    wire [7:0] dop = st_fetch ? mem_rdata : opc_ff;

    // bit-test forms; stack forms follow the prefix
    wire d_imm = ~pre_ff & (dop == `BCBT_OP_BT_IMM); // [RULE6]
    wire d_dir = ~pre_ff & (dop == `BCBT_OP_BT_DIR); // [RULE6]
    wire d_ext = ~pre_ff & (dop == `BCBT_OP_BT_EXT); // [RULE6]
    wire d_ix2 = ~pre_ff & (dop == `BCBT_OP_BT_IX2); // [RULE6]
    wire d_ix1 = ~pre_ff & (dop == `BCBT_OP_BT_IX1); // [RULE6]
    wire d_ix = ~pre_ff & (dop == `BCBT_OP_BT_IX); // [RULE6]
    wire d_sp2 = pre_ff & (dop == `BCBT_OP_BT_SP2); // [RULE6]
    wire d_sp1 = pre_ff & (dop == `BCBT_OP_BT_SP1); // [RULE6]

    // branch decode and condition
    wire cond_br;
    wire cond_take;
    wire d_br = ~pre_ff & cond_br;
    wire d_two = d_ext | d_ix2 | d_sp2;
    wire d_bt = d_imm | d_dir | d_two | d_ix1 | d_ix | d_sp1;
    wire d_valid = d_br | d_bt;

    // flag values from the helper
    wire bt_n;
    wire bt_z;
    wire mv_n;
    wire mv_z;

    // cycle bookkeeping
    wire [2:0] cnt_inc = cnt_ff + 3'h1;
    wire done_now = (cnt_inc >= need_ff);

    // offset sign-extended onto opcode address plus two
    wire [15:0] rel_ext = {{8{mem_rdata[7]}}, mem_rdata}; // [RULE15]
    wire [15:0] br_target = opa_ff + `BCBT_REL_BASE + rel_ext; // [RULE3]

    // address offsets of the indexed and stack forms
    wire [15:0] off8 = {8'h00, mem_rdata};
    wire [15:0] off16 = {b1_ff, mem_rdata};

    // apb phases
    wire apb_setup = psel & ~penable & ce;
    wire apb_wr = psel & penable & pwrite & ce;

    bcbt_cond u_cond (
        .opcode(dop),
        .condition_flag_register(ccr_ff),
        .irq_pin(irq_pin),
        .is_branch(cond_br),
        .take(cond_take)
    );

    bcbt_flags u_flags (
        .acc(acc_ff),
        .opnd(mem_rdata),
        .mv_wide(mv_wide),
        .mv_data(mv_data),
        .bt_n(bt_n),
        .bt_z(bt_z),
        .mv_n(mv_n),
        .mv_z(mv_z)
    );

    // cycles of the decoded form
    always @* begin
        if (d_br) begin
            d_need = `BCBT_CYC_BR; // [RULE3]
        end else if (d_imm) begin
            d_need = `BCBT_CYC_IMM;
        end else if (d_dir) begin
            d_need = `BCBT_CYC_DIR;
        end else if (d_ext) begin
            d_need = `BCBT_CYC_EXT;
        end else if (d_ix2) begin
            d_need = `BCBT_CYC_IX2;
        end else if (d_ix1) begin
            d_need = `BCBT_CYC_IX1;
        end else if (d_ix) begin
            d_need = `BCBT_CYC_IX;
        end else if (d_sp2) begin
            d_need = `BCBT_CYC_SP2;
        end else begin
            d_need = `BCBT_CYC_SP1;
        end
    end

    // register read decode; unused bits read as zero, except flag bits 6:5, which read as one
    always @* begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `BCBT_CTRL_OFS: begin
                rd_mux[`BCBT_CTRL_RUN] = run_ff;
                rd_mux[`BCBT_CTRL_STEP] = step_ff;
            end
            `BCBT_STAT_OFS: begin
                rd_mux[`BCBT_STAT_BUSY] = ~st_idle;
                rd_mux[`BCBT_STAT_ILL] = ill_ff;
                rd_mux[15:8] = opc_ff;
            end
            `BCBT_PC_OFS: rd_mux[15:0] = pc_ff;
            `BCBT_ACC_OFS: rd_mux[7:0] = acc_ff;
            `BCBT_HX_OFS: rd_mux[15:0] = hx_ff;
            `BCBT_SP_OFS: rd_mux[15:0] = sp_ff;
            `BCBT_CCR_OFS: rd_mux[7:0] = ccr_ff | `BCBT_CCR_ONES;
            default: hit = 1'b0;
        endcase
    end

    // software writes first, hardware after,
    // so the hardware update beats a same-cycle software write
    always @* begin
        nxt_pc = pc_ff;
        nxt_acc = acc_ff;
        nxt_hx = hx_ff;
        nxt_sp = sp_ff;
        nxt_ccr = ccr_ff;
        nxt_st = st_ff;
        nxt_opa = opa_ff;
        nxt_opc = opc_ff;
        nxt_pre = pre_ff;
        nxt_b1 = b1_ff;
        nxt_ea = ea_ff;
        nxt_cnt = cnt_ff;
        nxt_need = need_ff;
        nxt_run = run_ff;
        nxt_step = step_ff;
        nxt_ill = ill_ff;
        fin = 1'b0;
        bt_exec = 1'b0;

        // register writes; pc, acc, hx, sp and flags change only while idle,
        // so only control and status writes can race the sequencer
        if (apb_wr) begin
            case (paddr)
                `BCBT_CTRL_OFS: begin
                    nxt_run = pwdata[`BCBT_CTRL_RUN];
                    if (pwdata[`BCBT_CTRL_STEP]) begin
                        nxt_step = 1'b1;
                    end
                end
                `BCBT_STAT_OFS: begin
                    if (pwdata[`BCBT_STAT_ILL]) begin
                        nxt_ill = 1'b0;
                    end
                end
                `BCBT_PC_OFS: if (st_idle) nxt_pc = pwdata[15:0];
                `BCBT_ACC_OFS: if (st_idle) nxt_acc = pwdata[7:0];
                `BCBT_HX_OFS: if (st_idle) nxt_hx = pwdata[15:0];
                `BCBT_SP_OFS: if (st_idle) nxt_sp = pwdata[15:0];
                `BCBT_CCR_OFS: if (st_idle) nxt_ccr = pwdata[7:0];
                default: nxt_run = run_ff;
            endcase
        end

        case (st_ff)
            // wait for run or a single step
            S_IDLE: begin
                if (run_ff | step_ff) begin
                    nxt_step = 1'b0;
                    nxt_cnt = 3'h0;
                    nxt_st = S_FETCH;
                end
            end
            // opcode byte or its prefix
            S_FETCH: begin
                if (~pre_ff & (mem_rdata == `BCBT_OP_PREFIX)) begin
                    nxt_pre = 1'b1; // [RULE6]
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_cnt = cnt_inc;
                end else if (d_valid) begin
                    nxt_opc = mem_rdata;
                    nxt_opa = pc_ff;
                    nxt_pc = pc_ff + 16'h0001;
                    nxt_cnt = cnt_inc;
                    nxt_need = d_need;
                    if (d_ix) begin
                        nxt_ea = hx_ff;
                        nxt_st = S_DATA;
                    end else begin
                        nxt_st = S_OP1;
                    end
                end else begin
                    // unknown code: stop rather than guess
                    nxt_ill = 1'b1;
                    nxt_run = 1'b0;
                    nxt_pre = 1'b0;
                    nxt_cnt = 3'h0;
                    nxt_st = S_IDLE;
                end
            end
            // offset, immediate, or first address byte
            S_OP1: begin
                nxt_b1 = mem_rdata;
                nxt_pc = pc_ff + 16'h0001;
                nxt_cnt = cnt_inc;
                if (d_br) begin
                    // flags are never touched by a branch
                    if (cond_take) begin
                        nxt_pc = br_target; // [RULE15] [RULE3]
                    end
                    fin = 1'b1;
                end else if (d_imm) begin
                    bt_exec = 1'b1;
                    fin = 1'b1;
                end else if (d_two) begin
                    nxt_st = S_OP2;
                end else if (d_dir) begin
                    nxt_ea = off8;
                    nxt_st = S_DATA;
                end else if (d_ix1) begin
                    nxt_ea = hx_ff + off8;
                    nxt_st = S_DATA;
                end else begin
                    nxt_ea = sp_ff + off8;
                    nxt_st = S_DATA;
                end
            end
            // second address byte of the 16-bit forms
            S_OP2: begin
                nxt_pc = pc_ff + 16'h0001;
                nxt_cnt = cnt_inc;
                nxt_st = S_DATA;
                if (d_ext) begin
                    nxt_ea = off16;
                end else if (d_ix2) begin
                    nxt_ea = hx_ff + off16;
                end else begin
                    nxt_ea = sp_ff + off16;
                end
            end
            // operand read and tested in one cycle
            S_DATA: begin
                nxt_cnt = cnt_inc;
                bt_exec = 1'b1;
                fin = 1'b1;
            end
            // pad to the cycle count
            S_HOLD: begin
                nxt_cnt = cnt_inc;
                fin = 1'b1;
            end
            default: begin
                nxt_st = S_IDLE;
            end
        endcase

        // end once its cycles are used up
        if (fin) begin
            if (done_now) begin
                nxt_cnt = 3'h0;
                nxt_pre = 1'b0;
                nxt_st = run_ff ? S_FETCH : S_IDLE;
            end else begin
                nxt_st = S_HOLD;
            end
        end

        // bit-test sets flags only; acc kept
        if (bt_exec) begin
            nxt_ccr[`BCBT_CCR_V] = 1'b0; // [RULE5]
            nxt_ccr[`BCBT_CCR_N] = bt_n; // [RULE5] [RULE4]
            nxt_ccr[`BCBT_CCR_Z] = bt_z; // [RULE5]
        end else if (mv_valid) begin
            // h, i and c kept
            nxt_ccr[`BCBT_CCR_V] = 1'b0;
            nxt_ccr[`BCBT_CCR_N] = mv_n; // [RULE11] [RULE12]
            nxt_ccr[`BCBT_CCR_Z] = mv_z;
        end
    end

    // state registers; a low enable freezes everything
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_ff <= `BCBT_PC_RST;
            acc_ff <= `BCBT_ACC_RST;
            hx_ff <= `BCBT_HX_RST;
            sp_ff <= `BCBT_SP_RST;
            ccr_ff <= `BCBT_CCR_RST;
            st_ff <= S_IDLE;
            opa_ff <= 16'h0000;
            opc_ff <= 8'h00;
            pre_ff <= 1'b0;
            b1_ff <= 8'h00;
            ea_ff <= 16'h0000;
            cnt_ff <= 3'h0;
            need_ff <= 3'h0;
            run_ff <= 1'b0;
            step_ff <= 1'b0;
            ill_ff <= 1'b0;
        end else if (ce) begin
            pc_ff <= nxt_pc;
            acc_ff <= nxt_acc;
            hx_ff <= nxt_hx;
            sp_ff <= nxt_sp;
            ccr_ff <= nxt_ccr;
            st_ff <= nxt_st;
            opa_ff <= nxt_opa;
            opc_ff <= nxt_opc;
            pre_ff <= nxt_pre;
            b1_ff <= nxt_b1;
            ea_ff <= nxt_ea;
            cnt_ff <= nxt_cnt;
            need_ff <= nxt_need;
            run_ff <= nxt_run;
            step_ff <= nxt_step;
            ill_ff <= nxt_ill;
        end
    end

    // read data latched in setup, held for access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    // zero wait unless the enable is low
    assign prdata = prdata_ff;
    assign pready = ce;
    assign pslverr = psel & penable & ~hit;

    // reads come from pc or the operand address
    assign mem_rd = ce & (st_ff[1] | st_ff[2] | st_ff[3] | st_ff[4]);
    assign mem_addr = st_data ? ea_ff : pc_ff;
    assign busy = ~st_idle;
endmodule
`default_nettype wire

// >>> rtl/bcbt_defs.vh
`ifndef BCBT_DEFS_VH
`define BCBT_DEFS_VH

// apb register byte offsets
`define BCBT_CTRL_OFS 8'h00
`define BCBT_STAT_OFS 8'h04
`define BCBT_PC_OFS 8'h08
`define BCBT_ACC_OFS 8'h0c
`define BCBT_HX_OFS 8'h10
`define BCBT_SP_OFS 8'h14
`define BCBT_CCR_OFS 8'h18

// control and status bit positions
`define BCBT_CTRL_RUN 0
`define BCBT_CTRL_STEP 1
`define BCBT_STAT_BUSY 0
`define BCBT_STAT_ILL 1

// flag register bit positions
`define BCBT_CCR_V 7
`define BCBT_CCR_H 4
`define BCBT_CCR_I 3
`define BCBT_CCR_N 2
`define BCBT_CCR_Z 1
`define BCBT_CCR_C 0
`define BCBT_CCR_ONES 8'h60

// reset values
`define BCBT_PC_RST 16'h0000
`define BCBT_SP_RST 16'h00ff
`define BCBT_HX_RST 16'h0000
`define BCBT_ACC_RST 8'h00
`define BCBT_CCR_RST 8'h68

// relative branch opcodes
`define BCBT_OP_LOWER_SAME 8'h23
`define BCBT_OP_LOWER 8'h25
`define BCBT_OP_NEGATIVE 8'h2b
`define BCBT_OP_MASK_CLEAR 8'h2c
`define BCBT_OP_PIN_LOW 8'h2e
`define BCBT_OP_PIN_HIGH 8'h2f
`define BCBT_OP_SIGNED_LESS 8'h91
`define BCBT_OP_SIGNED_LE 8'h93

// bit-test opcodes; stack forms follow the prefix
`define BCBT_OP_PREFIX 8'h9e
`define BCBT_OP_BT_IMM 8'ha5
`define BCBT_OP_BT_DIR 8'hb5
`define BCBT_OP_BT_EXT 8'hc5
`define BCBT_OP_BT_IX2 8'hd5
`define BCBT_OP_BT_IX1 8'he5
`define BCBT_OP_BT_IX 8'hf5
`define BCBT_OP_BT_SP2 8'hd5
`define BCBT_OP_BT_SP1 8'he5

// branch target base and cycles per form
`define BCBT_REL_BASE 16'h0002
`define BCBT_CYC_BR 3'h3
`define BCBT_CYC_IMM 3'h2
`define BCBT_CYC_DIR 3'h3
`define BCBT_CYC_EXT 3'h4
`define BCBT_CYC_IX2 3'h4
`define BCBT_CYC_IX1 3'h3
`define BCBT_CYC_IX 3'h3
`define BCBT_CYC_SP2 3'h5
`define BCBT_CYC_SP1 3'h4

`endif

// >>> rtl/bcbt_flags.v
`timescale 1ns/10ps
`default_nettype none

// flag values for bit-test and for register moves
module bcbt_flags (
    // bit-test operands
    input wire [7:0] acc,
    input wire [7:0] opnd,
    // value moved by a load or store
    input wire mv_wide,
    input wire [15:0] mv_data,
    // bit-test flags
    output wire bt_n,
    output wire bt_z,
    // move flags
    output wire mv_n,
    output wire mv_z
);
    // the and result is never stored
    wire [7:0] and_res = acc & opnd; // [RULE4]

    assign bt_n = and_res[7]; // [RULE5]
    assign bt_z = (and_res == 8'h00); // [RULE5]

    // n follows the msb of the byte or pair moved
    assign mv_n = mv_wide ? mv_data[15] : mv_data[7]; // [RULE11]
    assign mv_z = mv_wide ? (mv_data == 16'h0000) : (mv_data[7:0] == 8'h00);
endmodule
`default_nettype wire

// >>> verification/bcbt_core_properties.sv
`timescale 1ns/10ps
`default_nettype none

// port-level sequencing checks
module bcbt_core_properties (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // memory, pin, status
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic irq_pin,
    input wire logic busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [15:0] a1, a2, a3; // address history
    logic [7:0] d1, d2; // read data history
    // history feeds consequents only, no reset
    always @(posedge pclk) begin
        a1 <= mem_addr;
        a2 <= a1;
        a3 <= a2;
        d1 <= mem_rdata;
        d2 <= d1;
    end
    wire [15:0] br_fall = a3 + 16'h0002; // not-taken target
    wire [15:0] br_tgt = br_fall + {{8{d2[7]}}, d2}; // taken target

    // limitation: operand bytes equal to an opcode would look like a fetch
    property pin_br(logic [7:0] op, logic lvl, logic tk);
        (ce && mem_rd && mem_rdata == op) ##1 (ce && mem_rd && irq_pin == lvl)
            ##1 (ce && !mem_rd) ##1 (ce && mem_rd) |-> mem_addr == (tk ? br_tgt : br_fall);
    endproperty

    a_pin_high_taken: assert property (pin_br(8'h2f, 1'b1, 1'b1))
        else $error("pin high target");
    a_pin_high_fall: assert property (pin_br(8'h2f, 1'b0, 1'b0))
        else $error("pin high fall");
    a_pin_low_taken: assert property (pin_br(8'h2e, 1'b0, 1'b1))
        else $error("pin low target");
    a_pin_low_fall: assert property (pin_br(8'h2e, 1'b1, 1'b0))
        else $error("pin low fall");
    a_branch_offset_read: assert property (
        (ce && mem_rd && mem_rdata inside {8'h23, 8'h25, 8'h2b, 8'h2c, 8'h2e, 8'h2f, 8'h91,
            8'h93}) ##1 ce |-> (mem_rd && mem_addr == a1 + 16'h0001) ##1 (!mem_rd || !ce))
        else $error("offset or pad");
    a_direct_address: assert property (
        (ce && mem_rd && mem_rdata == 8'hb5) ##1 ce[*2] |-> mem_rd && mem_addr == {8'h00, d1})
        else $error("direct address");
    a_extended_address: assert property (
        (ce && mem_rd && mem_rdata == 8'hc5) ##1 ce[*3] |-> mem_rd && mem_addr == {d2, d1})
        else $error("extended address");
    a_immediate_length: assert property (
        (ce && mem_rd && mem_rdata == 8'ha5) ##1 ce ##1 (ce && mem_rd) |-> mem_addr == a2 + 16'h0002)
        else $error("immediate length");
    a_ready_is_ce: assert property (pready == ce)
        else $error("ready not ce");
    a_unmapped_error: assert property (psel && penable && paddr == 8'h1c |-> pslverr)
        else $error("unmapped no error");
    a_mapped_no_error: assert property (psel && penable && paddr == 8'h18 |-> !pslverr)
        else $error("mapped error");

    c_pin_taken: cover property ((mem_rd && mem_rdata == 8'h2f) ##1 (mem_rd && irq_pin));
    c_direct: cover property (mem_rd && mem_rdata == 8'hb5);
    c_unmapped: cover property (pslverr);
endmodule

bind bcbt_core bcbt_core_properties chk_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .irq_pin(irq_pin), .busy(busy)
);

`default_nettype wire

// >>> verification/bcbt_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// async-read program memory and interrupt pin
module bcbt_mem_model (
    // clock and read port
    input wire logic pclk,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata,
    // interrupt pin level
    output logic irq_pin
);
    logic [7:0] mem [0:65535]; // bench loads it directly
    logic [7:0] last; // last byte handed out
    logic irq_lvl; // pin level from the bench

    // zero is undecoded, so stray runs halt
    initial begin
        irq_lvl = 1'b0;
        last = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
    end

    // last read, for the idle bus
    always @(posedge pclk) begin
        if (mem_rd) begin
            last <= mem[mem_addr];
        end
    end

    // idle bus shows the inverse of the last byte
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
    assign irq_pin = irq_lvl;
endmodule

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcbt_defs.vh"

module testbench;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, mem_rdata, op, fl, rel, acc;
    logic [31:0] pwdata, prdata, rd;
    logic mem_rd, irq_pin, mv_valid, mv_wide, busy, lv, tk;
    logic [15:0] mem_addr, mv_data;
    logic [39:0] bt;
    int num_errors, checks_done, busy_cnt, base, cyc, i, k;
    // branch cases: opcode, flags, pin level, taken
    logic [17:0] br_tab [0:18] = '{{8'h2f, 8'h00, 2'b11}, {8'h2f, 8'h00, 2'b00},
        {8'h2e, 8'h00, 2'b01}, {8'h2e, 8'h00, 2'b10}, {8'h93, 8'h02, 2'b01},
        {8'h93, 8'h04, 2'b01}, {8'h93, 8'h84, 2'b00}, {8'h93, 8'h80, 2'b01},
        {8'h25, 8'h01, 2'b01}, {8'h25, 8'h9e, 2'b00}, {8'h23, 8'h02, 2'b01},
        {8'h23, 8'h01, 2'b01}, {8'h23, 8'h9c, 2'b00}, {8'h2b, 8'h04, 2'b01},
        {8'h2b, 8'h9b, 2'b00}, {8'h91, 8'h80, 2'b01}, {8'h91, 8'h84, 2'b00},
        {8'h2c, 8'h00, 2'b01}, {8'h2c, 8'h9f, 2'b00}};
    // bit-test: code bytes, length, cycles; operands at 0080, 0090
    logic [39:0] bt_tab [0:7] = '{{32'ha5810000, 8'h22}, {32'hb5900000, 8'h23},
        {32'hc5009000, 8'h34}, {32'hd5001000, 8'h34}, {32'he5100000, 8'h23},
        {32'hf5000000, 8'h13}, {32'h9ed50010, 8'h45}, {32'h9ee51000, 8'h34}};
    // move cases: wide, value, flags after
    logic [24:0] mv_tab [0:3] = '{{1'b0, 16'h0080, 8'h65}, {1'b0, 16'h8000, 8'h63},
        {1'b1, 16'h8000, 8'h65}, {1'b1, 16'h0000, 8'h63}};

    bcbt_core dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .irq_pin(irq_pin), .mv_valid(mv_valid), .mv_wide(mv_wide), .mv_data(mv_data),
        .busy(busy));
    bcbt_mem_model mem_u (.pclk(pclk), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .irq_pin(irq_pin));

    // 125 mhz clock
    always #4 pclk = ~pclk;

    // busy cycles, for timing
    always @(posedge pclk) begin
        if (busy === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, entered after a clock edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // run from pc to the halting zero byte; pc to rd, cycles to cyc
    task run(input logic [15:0] pc);
        int n, s;
        apb(1'b1, `BCBT_PC_OFS, {16'h0000, pc});
        s = busy_cnt;
        apb(1'b1, `BCBT_CTRL_OFS, 32'h1);
        n = 0;
        while ((busy === 1'b1 || n < 3) && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 200) num_errors++;
        cyc = busy_cnt - s;
        apb(1'b0, `BCBT_PC_OFS, 32'h0);
    endtask

    // verdict
    task results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, far past the test length
    initial begin
        #400000;
        num_errors++;
        results;
    end

    initial begin
        {pclk, presetn, ce, psel, penable, pwrite, mv_valid, mv_wide} = 8'h00;
        {paddr, pwdata, mv_data, num_errors, checks_done, busy_cnt} = '0;
        ce = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values: ctrl, status, pc, acc, hx, sp, flags
        for (i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, (i == 5) ? 32'h00ff : (i == 6) ? 32'h0068 : 32'h0);
        end
        apb(1'b0, 8'h1c, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
        // baseline: only the halting byte
        run(16'h0040);
        chk(rd, 32'h0040);
        base = cyc;
        apb(1'b0, `BCBT_STAT_OFS, 32'h0);
        chk(rd[1:0], 2'b10);
        for (i = 0; i < 19; i++) begin
            {op, fl, lv, tk} = br_tab[i];
            rel = i[0] ? 8'h80 : 8'h7f;
            mem_u.mem[16'h0040] = op;
            mem_u.mem[16'h0041] = rel;
            mem_u.irq_lvl <= lv;
            apb(1'b1, `BCBT_CCR_OFS, {24'h0, fl});
            run(16'h0040);
            chk(rd, tk ? 16'h0042 + {{8{rel[7]}}, rel} : 16'h0042);
            chk(cyc - base, 3);
            apb(1'b0, `BCBT_CCR_OFS, 32'h0);
            chk(rd, {24'h0, fl | 8'h60});
        end
        apb(1'b1, `BCBT_HX_OFS, 32'h0080);
        apb(1'b1, `BCBT_SP_OFS, 32'h0080);
        mem_u.mem[16'h0080] = 8'h81;
        mem_u.mem[16'h0090] = 8'h81;
        for (i = 0; i < 16; i++) begin
            bt = bt_tab[i / 2];
            k = i % 2;
            for (int j = 0; j < 4; j++) begin
                mem_u.mem[16'h0040 + j] = bt[39 - 8 * j -: 8];
            end
            acc = k ? 8'h3c : 8'hc3;
            apb(1'b1, `BCBT_ACC_OFS, {24'h0, acc});
            apb(1'b1, `BCBT_CCR_OFS, k ? 32'h8c : 32'h93);
            run(16'h0040);
            chk(rd, 32'h0040 + bt[7:4]);
            chk(cyc - base, bt[3:0]);
            apb(1'b0, `BCBT_ACC_OFS, 32'h0);
            chk(rd, {24'h0, acc});
            apb(1'b0, `BCBT_CCR_OFS, 32'h0);
            chk(rd, k ? 32'h6a : 32'h75);
        end
        apb(1'b1, `BCBT_CCR_OFS, 32'h81);
        for (i = 0; i < 4; i++) begin
            mv_valid <= 1'b1;
            {mv_wide, mv_data} <= mv_tab[i][24:8];
            @(posedge pclk);
            mv_valid <= 1'b0;
            @(posedge pclk);
            apb(1'b0, `BCBT_CCR_OFS, 32'h0);
            chk(rd, {24'h0, mv_tab[i][7:0]});
        end
        results;
    end
endmodule

`default_nettype wire
